/* File: inc/usmpc_regs.vh */
/*
 Register offsets, field positions, reset values and mode codes of the serial
 port mode and pin control block.
 Assumes a 32-bit APB bus with byte addresses, one register per aligned word.
*/
`ifndef USMPC_REGS_VH
`define USMPC_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define USMPC_ADDR_TXCTL   8'h00
`define USMPC_ADDR_RXCTL   8'h04
`define USMPC_ADDR_DATA    8'h08
`define USMPC_ADDR_STAT    8'h0C

// ----------------------------------------------------------------------------
// Transmit status and control fields
// ----------------------------------------------------------------------------
`define USMPC_TX_CLKSRC    7
`define USMPC_TX_NINE      6
`define USMPC_TX_EN        5
`define USMPC_TX_SYNC      4
`define USMPC_TX_EMPTY     1
`define USMPC_TX_BIT9      0
`define USMPC_TX_WMASK     8'hF1

// ----------------------------------------------------------------------------
// Receive control fields
// ----------------------------------------------------------------------------
`define USMPC_RX_PEN       7
`define USMPC_RX_NINE      6
`define USMPC_RX_SINGLE    5
`define USMPC_RX_CONT      4
`define USMPC_RX_WMASK     8'hF0

// ----------------------------------------------------------------------------
// Reset values, mode codes and transmit FIFO size
// ----------------------------------------------------------------------------
`define USMPC_TX_RESET     8'h02
`define USMPC_RX_RESET     8'h00
`define USMPC_MODE_OFF     2'h0
`define USMPC_MODE_ASYNC   2'h1
`define USMPC_MODE_SMAST   2'h2
`define USMPC_MODE_SSLV    2'h3
`define USMPC_FIFO_DEPTH   16
`define USMPC_FIFO_AW      4

`endif

/* File: hw/usmpc_fifo.v */
/*
 Synchronous FIFO with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module usmpc_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             rst_b,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule // usmpc_fifo

/* File: hw/usmpc_top.v */
/*
 Mode selection and shared pin direction control of a combined synchronous and
 asynchronous serial port, with its transmit and receive control registers.
 Assumes an APB master on sys_clk and an external shift datapath that consumes
 transmit words and reports received bytes and shifter state.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
// Summary of operation
// - Asynchronous mode lets transmit and receive run together, independently.
// - Synchronous mode works as master or slave, one direction at a time.
// - Shared pins serve the port only while port enable is set.
// - Pin directions follow port, transmit, single and continuous enables and clock source.
// - Single receive enable takes one byte in synchronous master mode, then hardware clears it.
// - Continuous receive runs until cleared and overrides single receive.
`timescale 1ns/1ps
`include "usmpc_regs.vh"
module usmpc_top (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst_b,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Shift datapath side
   output wire [1:0]  mode,
   output wire        master_sel,
   output wire        tx_active,
   output wire        rx_active,
   output wire        tx_word_valid,
   input  wire        tx_word_ready,
   output wire [8:0]  tx_word,
   input  wire        shifter_empty,
   input  wire        rx_byte_done,
   // Shared pins
   input  wire        rx_data_pin_i,
   output wire        rx_data_pin_o,
   output wire        rx_data_pin_oe,
   input  wire        tx_clk_pin_i,
   output wire        tx_clk_pin_o,
   output wire        tx_clk_pin_oe,
   // Link values to and from the shift datapath
   input  wire        tx_serial,
   input  wire        sync_clk_out,
   output wire        rx_serial,
   output wire        sync_clk_in
);

   reg  [7:0] txctl_q;
   reg  [7:0] rxctl_q;
   wire       wr_en;
   wire       rd_en;
   wire       pen;
   wire       sync_mode;
   wire       rx_en;
   wire       fifo_in_ready;

   // -------------------------------------------------------------------------
   // APB access
   // -------------------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~((paddr == `USMPC_ADDR_TXCTL) | (paddr == `USMPC_ADDR_RXCTL)
                    | (paddr == `USMPC_ADDR_DATA) | (paddr == `USMPC_ADDR_STAT));
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;

   // Read data is registered in the setup cycle so it is valid in the access phase.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         case (paddr)
            `USMPC_ADDR_TXCTL: prdata <= {24'h000000, txctl_q[7:4], 2'h0, shifter_empty, txctl_q[0]};
            `USMPC_ADDR_RXCTL: prdata <= {24'h000000, rxctl_q[7:4], 4'h0};
            `USMPC_ADDR_STAT:  prdata <= {28'h0000000, fifo_in_ready, tx_word_valid, mode};
            default:           prdata <= 32'h00000000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------------------
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         txctl_q <= `USMPC_TX_RESET;
         rxctl_q <= `USMPC_RX_RESET;
      end else begin
         if (wr_en && paddr == `USMPC_ADDR_TXCTL) begin
            txctl_q <= (pwdata[7:0] & `USMPC_TX_WMASK) | `USMPC_TX_RESET;
         end
         // A byte completing in the write cycle still clears single receive.
         if (wr_en && paddr == `USMPC_ADDR_RXCTL) begin
            rxctl_q <= pwdata[7:0] & `USMPC_RX_WMASK;
            if (rx_byte_done && sync_mode && rxctl_q[`USMPC_RX_SINGLE]) begin
               rxctl_q[`USMPC_RX_SINGLE] <= 1'b0;
            end
         end else if (rx_byte_done && sync_mode && !rxctl_q[`USMPC_RX_CONT]) begin
            rxctl_q[`USMPC_RX_SINGLE] <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------------
   assign pen        = rxctl_q[`USMPC_RX_PEN];
   assign sync_mode  = txctl_q[`USMPC_TX_SYNC];
   assign master_sel = sync_mode & txctl_q[`USMPC_TX_CLKSRC];
   assign mode       = !pen ? `USMPC_MODE_OFF : !sync_mode ? `USMPC_MODE_ASYNC :
                       master_sel ? `USMPC_MODE_SMAST : `USMPC_MODE_SSLV;
   // Continuous overrides single; single is ignored in slave reception.
   assign rx_en      = rxctl_q[`USMPC_RX_CONT] | (rxctl_q[`USMPC_RX_SINGLE] & master_sel);
   // Asynchronous: both directions independent; synchronous: receive wins.
   assign rx_active  = pen & (sync_mode ? rx_en : rxctl_q[`USMPC_RX_CONT]);
   assign tx_active  = pen & txctl_q[`USMPC_TX_EN] & ~(sync_mode & rx_en);

   // -------------------------------------------------------------------------
   // Pin direction
   // -------------------------------------------------------------------------
   // Data pin drives only in synchronous transmit; clock pin in async tx or master.
   assign rx_data_pin_oe = pen & sync_mode & tx_active;
   assign rx_data_pin_o  = tx_serial;
   assign tx_clk_pin_oe  = pen & (sync_mode ? master_sel : txctl_q[`USMPC_TX_EN]);
   assign tx_clk_pin_o   = sync_mode ? sync_clk_out : tx_serial;
   assign rx_serial      = pen ? rx_data_pin_i : 1'b1;
   assign sync_clk_in    = pen & sync_mode & ~master_sel & tx_clk_pin_i;

   // -------------------------------------------------------------------------
   // Transmit word buffer
   // -------------------------------------------------------------------------
   usmpc_fifo #(
      .WIDTH (9),
      .DEPTH (`USMPC_FIFO_DEPTH),
      .AW    (`USMPC_FIFO_AW)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .in_valid  (wr_en && paddr == `USMPC_ADDR_DATA),
      .in_ready  (fifo_in_ready),
      .in_data   ({txctl_q[`USMPC_TX_BIT9] & txctl_q[`USMPC_TX_NINE], pwdata[7:0]}),
      .out_valid (tx_word_valid),
      .out_ready (tx_word_ready & tx_active),
      .out_data  (tx_word)
   );

endmodule // usmpc_top

/* File: verification/usmpc_props.sv */
/* Port assertions of the serial port mode and pin control block.
   Assumes a bind onto usmpc_top and one clock domain. */
`timescale 1ns/1ps
`include "usmpc_regs.vh"
module usmpc_props (
   input wire        sys_clk, rst_b, psel, penable, pwrite, master_sel, tx_active, rx_active, tx_serial,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [1:0]  mode,
   input wire        rx_data_pin_i, rx_data_pin_o, rx_data_pin_oe, tx_clk_pin_i, tx_clk_pin_o, tx_clk_pin_oe,
   input wire        sync_clk_out, rx_serial, sync_clk_in
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_pen_write;
      psel && penable && pwrite && paddr == `USMPC_ADDR_RXCTL && pwdata[`USMPC_RX_PEN];
   endsequence
   property p_pen_on; s_pen_write |=> mode != `USMPC_MODE_OFF; endproperty
   property p_off; mode == `USMPC_MODE_OFF |-> !rx_data_pin_oe && !tx_clk_pin_oe && rx_serial; endproperty
   property p_async; mode == `USMPC_MODE_ASYNC |-> !master_sel && rx_serial == rx_data_pin_i; endproperty
   property p_half; mode[1] |-> !(tx_active && rx_active); endproperty
   property p_data_dir; rx_data_pin_oe |-> mode[1] && tx_active && rx_data_pin_o == tx_serial; endproperty
   property p_master;
      mode == `USMPC_MODE_SMAST |-> master_sel && tx_clk_pin_oe && tx_clk_pin_o == sync_clk_out;
   endproperty
   property p_slave; mode == `USMPC_MODE_SSLV |-> !tx_clk_pin_oe && !master_sel && sync_clk_in == tx_clk_pin_i; endproperty
   a_pen_on: assert property (p_pen_on) else $error("mode off after enable");
   a_off: assert property (p_off) else $error("pins driven while off");
   a_async: assert property (p_async) else $error("async receive path wrong");
   a_half: assert property (p_half) else $error("both directions in sync");
   a_data_dir: assert property (p_data_dir) else $error("data pin direction wrong");
   a_master: assert property (p_master) else $error("master clock pin wrong");
   a_slave: assert property (p_slave) else $error("slave clock pin wrong");
endmodule // usmpc_props
bind usmpc_top usmpc_props u_props (.*);

/* File: verification/usmpc_peer.sv */
/* Far-side serial peripheral: drives the shared pins when the block releases them.
   Assumes pin triplets whose enable is high while the block drives. */
`timescale 1ns/1ps
module usmpc_peer (
   input  wire sys_clk, rst_b, clk_run, data_o, data_oe, clk_o, clk_oe,
   output wire data_i, clk_i
);
   reg pat_q, ck_q;
   // Data toggles every cycle so a stale level never passes for a match.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pat_q <= 1'b1;
         ck_q  <= 1'b1;
      end else begin
         pat_q <= ~pat_q;
         ck_q  <= clk_run ? ~ck_q : 1'b1;
      end
   end
   assign data_i = data_oe ? data_o : pat_q;
   assign clk_i  = clk_oe ? clk_o : ck_q;
endmodule // usmpc_peer

/* File: verification/usmpc_top_tb.sv */
/* Self-checking testbench of the serial port mode and pin control block.
   Assumes the APB slave, the peer model and the checker bound to the top. */
`timescale 1ns/1ps
`include "usmpc_regs.vh"
module usmpc_top_tb;
   reg        sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_run = 1'b0;
   reg        tx_word_ready = 1'b0, shifter_empty = 1'b1, rx_byte_done = 1'b0, tx_serial = 1'b0, sync_clk_out = 1'b0;
   reg [7:0]  paddr = 8'h00;
   reg [31:0] pwdata = 32'h0, r;
   reg        e;
   wire       pready, pslverr, master_sel, tx_active, rx_active, tx_word_valid, rx_serial, sync_clk_in;
   wire       rx_data_pin_i, rx_data_pin_o, rx_data_pin_oe, tx_clk_pin_i, tx_clk_pin_o, tx_clk_pin_oe;
   wire [31:0] prdata;
   wire [1:0] mode;
   wire [8:0] tx_word;
   wire [6:0] st = {mode, master_sel, tx_active, rx_active, rx_data_pin_oe, tx_clk_pin_oe};
   int        errors = 0, checks_done = 0, i;
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      tx_serial    <= ~tx_serial;
      sync_clk_out <= ~sync_clk_out;
   end
   usmpc_top uut (.*);
   usmpc_peer peer (.sys_clk, .rst_b, .clk_run, .data_o(rx_data_pin_o), .data_oe(rx_data_pin_oe),
      .clk_o(tx_clk_pin_o), .clk_oe(tx_clk_pin_oe), .data_i(rx_data_pin_i), .clk_i(tx_clk_pin_i));
   task cmp(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task cst(input logic [6:0] exp);
      #1 cmp("pins", {25'h0, exp}, {25'h0, st});
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp("register", exp, r);
   endtask
   task byte_done;
      @(posedge sys_clk) rx_byte_done <= 1'b1;
      @(posedge sys_clk) rx_byte_done <= 1'b0;
   endtask
   task t_reset;
      cst(7'h00);
      rd(`USMPC_ADDR_TXCTL, 32'h02);
      shifter_empty <= 1'b0;
      rd(`USMPC_ADDR_TXCTL, 32'h00);
      shifter_empty <= 1'b1;
      rd(`USMPC_ADDR_RXCTL, 32'h00);
   endtask
   task t_async_fifo;
      wr(`USMPC_ADDR_TXCTL, 32'hA0);
      wr(`USMPC_ADDR_RXCTL, 32'h90);
      cst(7'h2D);
      wr(`USMPC_ADDR_RXCTL, 32'h80);
      for (int k = 0; k < 17; k++) wr(`USMPC_ADDR_DATA, k);
      rd(`USMPC_ADDR_STAT, 32'h5);
      tx_word_ready <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         #1 cmp("word", k, {23'h0, tx_word});
         @(posedge sys_clk);
      end
      #1 cmp("drained", 32'h0, {31'h0, tx_word_valid});
      tx_word_ready <= 1'b0;
   endtask
   task t_sync;
      wr(`USMPC_ADDR_TXCTL, 32'hB0);
      cst(7'h5B);
      wr(`USMPC_ADDR_RXCTL, 32'hA0);
      cst(7'h55);
      byte_done;
      cst(7'h5B);
      rd(`USMPC_ADDR_RXCTL, 32'h80);
      wr(`USMPC_ADDR_RXCTL, 32'hB0);
      byte_done;
      rd(`USMPC_ADDR_RXCTL, 32'hB0);
      wr(`USMPC_ADDR_TXCTL, 32'h30);
      cst(7'h64);
      clk_run <= 1'b1;
      wr(`USMPC_ADDR_RXCTL, 32'h80);
      cst(7'h6A);
      clk_run <= 1'b0;
   endtask
   task t_map;
      apb(1'b0, 8'h10, 32'h0);
      cmp("slverr", 32'h1, {31'h0, e});
      wr(`USMPC_ADDR_RXCTL, 32'h0);
      wr(`USMPC_ADDR_TXCTL, 32'hFF);
      rd(`USMPC_ADDR_TXCTL, 32'hF3);
      cst(7'h10);
      wr(`USMPC_ADDR_DATA, 32'h5A);
      #1 cmp("ninth", 32'h15A, {23'h0, tx_word});
   endtask
   task end_sim;
      $display("Comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset;
      t_async_fifo;
      t_sync;
      t_map;
      end_sim;
   end
   initial begin
      #400000;
      errors++;
      end_sim;
   end
endmodule // usmpc_top_tb
